//--- dv/scg_host_model.sv
// Host side model: holds the speed select pins and the analog reference as levels
module scg_host_model (
  input  wire logic               clk_i,               // System clock
  input  wire logic [1:0]         sel_req_i,           // Requested pattern, bit1 is MSB
  input  wire logic signed [15:0] analog_req_i,        // Requested analog sample
  output logic                    speed_select_bit0_o, // Select pin 0, on = 1
  output logic                    speed_select_bit1_o, // Select pin 1, on = 1
  output logic signed [15:0]      analog_ref_o         // Analog reference sample
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins change just after an edge and then stand as levels
  always @(posedge clk_i) begin
    speed_select_bit0_o <= sel_req_i[0];
    speed_select_bit1_o <= sel_req_i[1];
    analog_ref_o <= analog_req_i;
  end
endmodule // scg_host_model

//--- dv/speed_command_select_loop_gain_test.sv
// Testbench: register bus, speed select and loop gain scenarios
module speed_command_select_loop_gain_test
  import scg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic clk_en = 1'b1;
  logic [1:0] sel_req = 2'h0;
  logic signed [15:0] analog_req = 16'sh0000;
  logic signed [15:0] analog_ref;
  logic signed [15:0] gain_adjust = 16'sh0005;
  logic sel0;
  logic sel1;
  scg_speed_out_t speed_cmd;
  scg_gain_out_t pos_gain;
  logic auto_tune;
  logic [31:0] rd;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int exp_preset [1:3] = '{5, -7, 9};

  always #12.5 clk_sys_i = ~clk_sys_i;

  scg_host_model HOST (.clk_i(clk_sys_i), .sel_req_i(sel_req), .analog_req_i(analog_req),
    .speed_select_bit0_o(sel0), .speed_select_bit1_o(sel1), .analog_ref_o(analog_ref));

  scg_speed_gain #(.MS_CYC(8)) DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hreadyout),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .speed_select_bit0_i(sel0),
    .speed_select_bit1_i(sel1), .analog_ref_i(analog_ref), .gain_adjust_i(gain_adjust),
    .speed_cmd_o(speed_cmd), .pos_gain_o(pos_gain), .auto_tune_active_o(auto_tune));

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; read data is taken at the edge ending the data phase
  task automatic bus(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {16'h0000, addr};
    hwrite <= wr;
    do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [15:0] addr, input logic [31:0] exp, input string what);
    bus(1'b0, addr, 32'h0000_0000);
    chk(rd, exp, what);
    chk(hresp, 1'b0, "okay response");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic pins(input logic [1:0] p, input logic signed [15:0] a);
    @(posedge clk_sys_i);
    sel_req <= p;
    analog_req <= a;
  endtask

  task automatic spd(input int n, input int exp, input logic tl, input string what);
    cyc(n);
    chk(64'(speed_cmd.value), 64'(exp), what);
    chk(speed_cmd.torque_limit, tl, what);
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rdchk(OFS_POS_KP, 32'h0000_0023, "kp reset");
    rdchk(OFS_POS_FF, 32'h0000_0032, "ff reset");
    rdchk(OFS_TUNING_MODE, 32'h0000_0000, "tuning reset");
    rdchk(16'h0300, 32'h0000_0000, "unmapped read");
    bus(1'b1, OFS_POS_KP, 32'h0000_0BB8);
    rdchk(OFS_POS_KP, 32'h0000_07FF, "kp clamp");
    bus(1'b1, OFS_POS_FF, 32'h0000_00C8);
    rdchk(OFS_POS_FF, 32'h0000_0064, "ff clamp");
    bus(1'b1, OFS_POS_KP, 32'h0000_007D);
    cyc(2);
    chk({auto_tune, pos_gain}, {1'b0, 16'h007D, 16'h0064}, "manual gains");
    bus(1'b1, OFS_TUNING_MODE, 32'h0000_0001);
    cyc(2);
    chk({auto_tune, pos_gain}, {1'b1, 16'h0082, 16'h0064}, "auto gains");
    @(posedge clk_sys_i);
    gain_adjust <= -16'sh0100;
    cyc(2);
    chk({auto_tune, pos_gain}, {1'b1, 16'h0000, 16'h0064}, "auto gain floor");
    bus(1'b1, OFS_TUNING_MODE, 32'h0000_0000);
    cyc(2);
    chk({auto_tune, pos_gain}, {1'b0, 16'h007D, 16'h0064}, "back to manual");
    bus(1'b1, OFS_ACCEL_TIME, 32'h0000_0000);
    rdchk(OFS_ACCEL_TIME, 32'h0000_0001, "accel clamp");
    bus(1'b1, OFS_DECEL_TIME, 32'h0000_0001);
    bus(1'b1, OFS_ANALOG_FS, 32'h0000_0008);
    bus(1'b1, OFS_PRESET_FIRST, 32'h0000_0005);
    bus(1'b1, OFS_PRESET_SECOND, 32'hFFFF_FFF9);
    bus(1'b1, OFS_PRESET_THIRD, 32'h0001_1170);
    rdchk(OFS_PRESET_THIRD, 32'h0000_EA60, "preset clamp");
    bus(1'b1, OFS_PRESET_THIRD, 32'h0000_0009);
    for (int p = 1; p < 4; p++) begin
      pins(p[1:0], 16'sh0000);
      spd(60, exp_preset[p], 1'b0, "preset select");
    end
    pins(2'h0, -16'sh1000);
    spd(8, -10, 1'b0, "analog bypass");
    rdchk(OFS_STATUS, 32'h00CF_FFF6, "status analog bypass");
    bus(1'b1, OFS_CTRL_MODE, 32'h0000_0001);
    spd(40, 0, 1'b0, "zero speed mode");
    bus(1'b1, OFS_CTRL_MODE, 32'h0000_0002);
    spd(8, -10, 1'b1, "torque mode limit");
    bus(1'b1, OFS_CTRL_MODE, 32'h0000_0003);
    spd(40, 0, 1'b1, "zero torque mode");
    pins(2'h1, 16'sh0000);
    spd(40, 5, 1'b1, "torque preset limit");
    bus(1'b1, OFS_ROUND_TIME, 32'h0000_0002);
    pins(2'h2, 16'sh0000);
    spd(100, -7, 1'b1, "rounded profile settles");
    pins(2'h3, 16'sh0000);
    clk_en <= 1'b0;
    spd(40, -7, 1'b1, "clock enable freeze");
    @(posedge clk_sys_i);
    clk_en <= 1'b1;
    spd(100, 9, 1'b1, "release after freeze");
    end_of_test();
  end
endmodule // speed_command_select_loop_gain_test

//--- src/scg_pkg.sv
// Package: constants, register map and carrier types of the speed command / loop gain block
package scg_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned CMD_W    = 21;
  localparam int unsigned PRESET_W = 17;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OFS_PRESET_FIRST  = 16'h0100;
  localparam logic [15:0] OFS_PRESET_SECOND = 16'h0104;
  localparam logic [15:0] OFS_PRESET_THIRD  = 16'h0108;
  localparam logic [15:0] OFS_CTRL_MODE     = 16'h010C;
  localparam logic [15:0] OFS_TUNING_MODE   = 16'h0110;
  localparam logic [15:0] OFS_ANALOG_FS     = 16'h0114;
  localparam logic [15:0] OFS_ACCEL_TIME    = 16'h0118;
  localparam logic [15:0] OFS_DECEL_TIME    = 16'h011C;
  localparam logic [15:0] OFS_ROUND_TIME    = 16'h0120;
  localparam logic [15:0] OFS_STATUS        = 16'h0124;
  localparam logic [15:0] OFS_POS_KP        = 16'h0200;
  localparam logic [15:0] OFS_POS_FF        = 16'h0204;

  // ---------------------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_POS_KP     = 16'h0023;
  localparam logic [15:0] RST_POS_FF     = 16'h0032;
  localparam logic [15:0] RST_ACCEL_TIME = 16'h00C8;
  localparam logic [15:0] RST_DECEL_TIME = 16'h00C8;
  localparam logic [15:0] RST_ROUND_TIME = 16'h0000;
  localparam logic [15:0] RST_ANALOG_FS  = 16'h0BB8;
  localparam logic [15:0] MAX_POS_KP     = 16'h07FF;
  localparam logic [15:0] MAX_POS_FF     = 16'h0064;
  localparam logic [15:0] MIN_RAMP_TIME  = 16'h0001;
  localparam logic [15:0] MAX_RAMP_TIME  = 16'h4E20;
  localparam logic [15:0] MAX_ROUND_TIME = 16'h2710;
  localparam logic signed [PRESET_W-1:0] PRESET_MAX = 17'sd60000;
  localparam logic signed [PRESET_W-1:0] PRESET_MIN = -17'sd60000;

  // ---------------------------------------------------------------------------
  // Timing: 3000 r/min is 30000 counts per ramp time; 30000 / (t_ms * 40000) = 3 / (4 * t_ms)
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam logic [2:0]  RAMP_STEP_MAX = 3'd3;

  // ---------------------------------------------------------------------------
  // Modes and carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCG_MODE_S  = 2'b00,
    SCG_MODE_SZ = 2'b01,
    SCG_MODE_T  = 2'b10,
    SCG_MODE_TZ = 2'b11
  } scg_mode_t;

  typedef struct packed {
    logic                    torque_limit;
    logic signed [CMD_W-1:0] value;
  } scg_speed_out_t;

  typedef struct packed {
    logic [15:0] prop_gain;
    logic [15:0] ff_gain;
  } scg_gain_out_t;

endpackage : scg_pkg

//--- src/scg_speed_gain.sv
// Speed command source selection, S-curve smoothing and position loop gain registers
//
// The implementer's own choice: register access over AHB-Lite.

module scg_speed_gain
  import scg_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES                    // Cycles per millisecond
) (
  input  wire logic                 clk_sys_i,                 // System clock, 40 MHz
  input  wire logic                 rst_b_i,                   // Async reset, active low
  input  wire logic                 clk_en_i,                  // Clock enable, freezes state when low
  input  wire logic                 hsel_i,                    // AHB slave select
  input  wire logic [31:0]          haddr_i,                   // AHB address
  input  wire logic [1:0]           htrans_i,                  // AHB transfer type
  input  wire logic                 hwrite_i,                  // AHB write
  input  wire logic [2:0]           hsize_i,                   // AHB size
  input  wire logic                 hready_i,                  // AHB bus ready
  input  wire logic [31:0]          hwdata_i,                  // AHB write data
  output logic [31:0]               hrdata_o,                  // AHB read data
  output logic                      hreadyout_o,               // AHB slave ready
  output logic                      hresp_o,                   // AHB response, always OKAY
  input  wire logic                 speed_select_bit0_i,       // Speed select pin 0, asynchronous
  input  wire logic                 speed_select_bit1_i,       // Speed select pin 1, asynchronous
  input  wire logic signed [15:0]   analog_ref_i,              // ADC sample, full scale = 10 V
  input  wire logic signed [15:0]   gain_adjust_i,             // Estimator gain correction
  output scg_speed_out_t            speed_cmd_o,               // Smoothed speed command or limit
  output scg_gain_out_t             pos_gain_o,                // Effective position loop gains
  output logic                      auto_tune_active_o         // Auto tuning running
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic signed [PRESET_W-1:0] preset [3];
  scg_mode_t                  control_mode_select;
  logic                       tuning_mode_select;
  logic [15:0]                analog_full_scale_speed;
  logic [15:0]                accel_time_constant;
  logic [15:0]                decel_time_constant;
  logic [15:0]                curve_rounding_time;
  logic [15:0]                position_prop_gain;
  logic [15:0]                position_ff_gain;

  // Assertions below all run on the system clock and stop during reset
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // ---------------------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------------------
  logic        dph_write;
  logic [15:0] dph_addr;
  wire         ahb_take   = hsel_i && htrans_i[1] && hready_i;
  wire  [15:0] addr_lo    = {haddr_i[15:2], 2'b00};
  wire         wr_strobe  = dph_write && clk_en_i;
  // Saturate on the whole written word, so that large values cannot wrap first
  wire  signed [31:0]         wdata_word   = $signed(hwdata_i);
  wire  signed [PRESET_W-1:0] wdata_preset = (wdata_word > 32'(PRESET_MAX)) ? PRESET_MAX :
                                             (wdata_word < 32'(PRESET_MIN)) ? PRESET_MIN :
                                             wdata_word[PRESET_W-1:0];
  logic [31:0] rd_mux;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dph_write   <= 1'b0;
      dph_addr    <= 16'h0000;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (clk_en_i) begin
      dph_write <= ahb_take && hwrite_i && (haddr_i[31:16] == 16'h0000);
      dph_addr  <= addr_lo;
      if (ahb_take && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // Register writes, time and gain values clamped to their legal ranges; analog full scale stored as written
  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      control_mode_select     <= SCG_MODE_S;
      tuning_mode_select      <= 1'b0;
      analog_full_scale_speed <= RST_ANALOG_FS;
      accel_time_constant     <= RST_ACCEL_TIME;
      decel_time_constant     <= RST_DECEL_TIME;
      curve_rounding_time     <= RST_ROUND_TIME;
      position_prop_gain      <= RST_POS_KP;
      position_ff_gain        <= RST_POS_FF;
    end else if (wr_strobe) begin
      case (dph_addr)
        OFS_CTRL_MODE:   control_mode_select     <= scg_mode_t'(hwdata_i[1:0]);
        OFS_TUNING_MODE: tuning_mode_select      <= hwdata_i[0];
        OFS_ANALOG_FS:   analog_full_scale_speed <= hwdata_i[15:0];
        OFS_ACCEL_TIME:  accel_time_constant     <= clamp_u(hwdata_i[15:0], MIN_RAMP_TIME, MAX_RAMP_TIME);
        OFS_DECEL_TIME:  decel_time_constant     <= clamp_u(hwdata_i[15:0], MIN_RAMP_TIME, MAX_RAMP_TIME);
        OFS_ROUND_TIME:  curve_rounding_time     <= clamp_u(hwdata_i[15:0], 16'h0000, MAX_ROUND_TIME);
        OFS_POS_KP:      position_prop_gain      <= clamp_u(hwdata_i[15:0], 16'h0000, MAX_POS_KP);
        OFS_POS_FF:      position_ff_gain        <= clamp_u(hwdata_i[15:0], 16'h0000, MAX_POS_FF);
        default: ;
      endcase
    end
  end

  // Preset registers saturate to the signed range
  for (genvar i = 0; i < 3; i++) begin : g_preset
    wire [15:0] ofs_i = OFS_PRESET_FIRST + 16'(4 * i);
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        preset[i] <= '0;
      end else if (wr_strobe && dph_addr == ofs_i) begin
        preset[i] <= wdata_preset;
      end
    end
  end

  a_preset_range: assert property (preset[0] <= PRESET_MAX && preset[0] >= PRESET_MIN &&
      preset[1] <= PRESET_MAX && preset[1] >= PRESET_MIN &&
      preset[2] <= PRESET_MAX && preset[2] >= PRESET_MIN)
    else $error("preset out of range");
  a_kp_range: assert property (position_prop_gain <= MAX_POS_KP && position_ff_gain <= MAX_POS_FF)
    else $error("gain register out of range");
  a_ramp_range: assert property (accel_time_constant >= MIN_RAMP_TIME &&
      decel_time_constant >= MIN_RAMP_TIME && curve_rounding_time <= MAX_ROUND_TIME)
    else $error("ramp time register out of range");

  // ---------------------------------------------------------------------------
  // Select pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] sel_s1;
  logic [1:0] sel_s2;
  logic [1:0] sel_s3;
  logic [1:0] sel_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_s1 <= 2'b00;
      sel_s2 <= 2'b00;
      sel_s3 <= 2'b00;
      sel_q  <= 2'b00;
    end else if (clk_en_i) begin
      sel_s1 <= {speed_select_bit1_i, speed_select_bit0_i};
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      if (sel_s2 == sel_s3) begin
        sel_q <= sel_s3;
      end
    end
  end

  a_sync_agree: assert property (clk_en_i && sel_s2 != sel_s3 |=> sel_q == $past(sel_q))
    else $error("select changed before synchroniser agreed");

  // ---------------------------------------------------------------------------
  // Command source selection
  // ---------------------------------------------------------------------------
  wire                     torque_mode = control_mode_select[1];
  wire                     zero_mode   = control_mode_select[0];
  wire                     analog_src  = (sel_q == 2'b00) && !zero_mode;
  wire signed [32:0]       an_prod     = analog_ref_i * $signed({1'b0, analog_full_scale_speed});
  wire signed [36:0]       an_prod10   = (37'(an_prod) <<< 3) + (37'(an_prod) <<< 1);
  wire signed [CMD_W-1:0]  analog_cmd  = an_prod10[35:15];
  logic signed [CMD_W-1:0] next_sel_cmd;
  logic signed [CMD_W-1:0] sel_cmd;

  always_comb begin
    case (sel_q)
      2'b00:   next_sel_cmd = zero_mode ? '0 : analog_cmd;
      2'b01:   next_sel_cmd = CMD_W'(preset[0]);
      2'b10:   next_sel_cmd = CMD_W'(preset[1]);
      2'b11:   next_sel_cmd = CMD_W'(preset[2]);
      default: next_sel_cmd = '0;
    endcase
  end

  // Registered every cycle: select or preset edits reach the filter next cycle
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_cmd <= '0;
    end else if (clk_en_i) begin
      sel_cmd <= next_sel_cmd;
    end
  end

  a_zero_speed_forced: assert property (clk_en_i && sel_q == 2'b00 && zero_mode |=> sel_cmd == '0)
    else $error("zero speed mode did not force zero");
  a_analog_follow: assert property (clk_en_i && analog_src |=> sel_cmd == $past(analog_cmd))
    else $error("analog command not followed");
  a_preset_pick: assert property (clk_en_i && sel_q != 2'b00 |=>
      sel_cmd == CMD_W'($past(preset[sel_q - 2'd1])))
    else $error("wrong preset selected");
  a_sel_next_cycle: assert property (clk_en_i |=> sel_cmd == $past(next_sel_cmd))
    else $error("selection not re-evaluated");

  // ---------------------------------------------------------------------------
  // S-curve smoothing
  // ---------------------------------------------------------------------------
  logic signed [CMD_W-1:0] out_cmd;
  logic [17:0]             ramp_err;
  logic [1:0]              accel_lvl;
  logic [31:0]             ms_cnt;
  logic [15:0]             jerk_cnt;
  wire                     bypass    = analog_src && (curve_rounding_time == 16'h0000);
  wire signed [CMD_W:0]    diff      = {sel_cmd[CMD_W-1], sel_cmd} - {out_cmd[CMD_W-1], out_cmd};
  wire                     moving    = (diff != '0);
  wire                     away      = (!diff[CMD_W] && !out_cmd[CMD_W-1]) ||
                                       (diff[CMD_W] && (out_cmd[CMD_W-1] || out_cmd == '0));
  wire [15:0]              t_const   = away ? accel_time_constant : decel_time_constant;
  wire [17:0]              thresh    = {t_const, 2'b00};
  wire [17:0]              err_sum   = ramp_err + 18'(accel_lvl);
  wire                     step_now  = (err_sum >= thresh);
  wire                     ms_tick   = (ms_cnt == 32'(MS_CYC - 1));
  wire                     no_round  = (curve_rounding_time == 16'h0000);
  wire [15:0]              jerk_len  = {1'b0, curve_rounding_time[15:1]};
  wire signed [CMD_W-1:0]  step_dir  = diff[CMD_W] ? -CMD_W'(1) : CMD_W'(1);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ms_cnt <= 32'h0000_0000;
    end else if (clk_en_i) begin
      ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
    end
  end

  // Error accumulator gives 3 / (4 * t_ms) counts per cycle at full acceleration level
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_cmd  <= '0;
      ramp_err <= 18'h0_0000;
    end else if (clk_en_i) begin
      if (bypass) begin
        out_cmd  <= sel_cmd;
        ramp_err <= 18'h0_0000;
      end else if (!moving) begin
        ramp_err <= 18'h0_0000;
      end else if (step_now) begin
        out_cmd  <= out_cmd + step_dir;
        ramp_err <= err_sum - thresh;
      end else begin
        ramp_err <= err_sum;
      end
    end
  end

  a_bypass_follow: assert property (clk_en_i && bypass |=> out_cmd == $past(sel_cmd))
    else $error("bypass did not pass command");
  a_step_bounded: assert property (clk_en_i && !bypass |=>
      (out_cmd - $past(out_cmd) == 1) || (out_cmd - $past(out_cmd) == -1) || out_cmd == $past(out_cmd))
    else $error("smoothed command jumped");

  // Acceleration level rises from 1 to 3 in two steps, each after half the rounding time plus one millisecond tick
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      accel_lvl <= 2'd1;
      jerk_cnt  <= 16'h0000;
    end else if (clk_en_i) begin
      if (no_round) begin
        accel_lvl <= 2'(RAMP_STEP_MAX);
        jerk_cnt  <= 16'h0000;
      end else if (!moving) begin
        accel_lvl <= 2'd1;
        jerk_cnt  <= 16'h0000;
      end else if (ms_tick && accel_lvl != 2'(RAMP_STEP_MAX)) begin
        if (jerk_cnt >= jerk_len) begin
          accel_lvl <= accel_lvl + 2'd1;
          jerk_cnt  <= 16'h0000;
        end else begin
          jerk_cnt <= jerk_cnt + 16'h0001;
        end
      end
    end
  end

  a_flat_ramp: assert property (clk_en_i && no_round |=> accel_lvl == 2'(RAMP_STEP_MAX))
    else $error("ramp level not full without rounding");

  // ---------------------------------------------------------------------------
  // Outputs: speed command or limit, effective gains
  // ---------------------------------------------------------------------------
  wire signed [16:0] kp_sum = $signed({1'b0, position_prop_gain}) + 17'(gain_adjust_i);
  wire [15:0]        kp_eff = kp_sum[16] ? 16'h0000 : clamp_u(kp_sum[15:0], 16'h0000, MAX_POS_KP);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      speed_cmd_o        <= '0;
      pos_gain_o         <= {RST_POS_KP, RST_POS_FF};
      auto_tune_active_o <= 1'b0;
    end else if (clk_en_i) begin
      speed_cmd_o.torque_limit <= torque_mode;
      speed_cmd_o.value        <= out_cmd;
      pos_gain_o.prop_gain     <= tuning_mode_select ? kp_eff : position_prop_gain;
      pos_gain_o.ff_gain       <= position_ff_gain;
      auto_tune_active_o       <= tuning_mode_select;
    end
  end

  a_manual_gain: assert property (clk_en_i && !tuning_mode_select |=>
      pos_gain_o.prop_gain == $past(position_prop_gain) && !auto_tune_active_o)
    else $error("manual tuning gain altered");
  a_auto_gain: assert property (clk_en_i && tuning_mode_select |=>
      auto_tune_active_o && pos_gain_o.prop_gain <= MAX_POS_KP)
    else $error("auto tuning gain out of range");
  a_ff_pass: assert property (clk_en_i |=> pos_gain_o.ff_gain == $past(position_ff_gain))
    else $error("feed-forward gain not applied");
  a_limit_flag: assert property (clk_en_i && torque_mode |=> speed_cmd_o.torque_limit)
    else $error("torque mode not flagged as limit");
  a_freeze_hold: assert property (!clk_en_i |=> $stable(out_cmd) && $stable(sel_q) && $stable(speed_cmd_o))
    else $error("state moved while clock enable low");

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  wire [31:0] status_word = {7'h00, speed_cmd_o.torque_limit, analog_src, bypass, sel_q, out_cmd[19:0]};
  always_comb begin
    case (addr_lo)
      OFS_PRESET_FIRST:  rd_mux = 32'(preset[0]);
      OFS_PRESET_SECOND: rd_mux = 32'(preset[1]);
      OFS_PRESET_THIRD:  rd_mux = 32'(preset[2]);
      OFS_CTRL_MODE:     rd_mux = {30'h0, control_mode_select};
      OFS_TUNING_MODE:   rd_mux = {31'h0, tuning_mode_select};
      OFS_ANALOG_FS:     rd_mux = {16'h0000, analog_full_scale_speed};
      OFS_ACCEL_TIME:    rd_mux = {16'h0000, accel_time_constant};
      OFS_DECEL_TIME:    rd_mux = {16'h0000, decel_time_constant};
      OFS_ROUND_TIME:    rd_mux = {16'h0000, curve_rounding_time};
      OFS_STATUS:        rd_mux = status_word;
      OFS_POS_KP:        rd_mux = {16'h0000, position_prop_gain};
      OFS_POS_FF:        rd_mux = {16'h0000, position_ff_gain};
      default:           rd_mux = 32'h0000_0000;
    endcase
    if (haddr_i[31:16] != 16'h0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

endmodule // scg_speed_gain
